// file: logic/cch_pkg.sv
/*
 * cch_pkg: shared constants for the counter compare/latch/hysteresis block.
 * Assumes a single 200 MHz clock and an APB register port with 32-bit data.
 */
package cch_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] CCH_OFS_CTRL   = 8'h00;	// commands and mode enables
	localparam logic [7:0] CCH_OFS_CFG    = 8'h04;	// condition, gates, hysteresis, pulse
	localparam logic [7:0] CCH_OFS_LOAD   = 8'h08;	// load value
	localparam logic [7:0] CCH_OFS_END    = 8'h0C;	// end value
	localparam logic [7:0] CCH_OFS_CMP    = 8'h10;	// compare value
	localparam logic [7:0] CCH_OFS_STATUS = 8'h14;	// status word, read only
	localparam logic [7:0] CCH_OFS_COUNT  = 8'h18;	// live count, read only
	localparam logic [7:0] CCH_OFS_LATCH  = 8'h1C;	// latched count, read only

	// ==========================================================
	// control word bit positions
	localparam int CCH_CTRL_GATE_SET   = 0;	// write 1: open software gate
	localparam int CCH_CTRL_GATE_CLR   = 1;	// write 1: close software gate
	localparam int CCH_CTRL_RST_EN     = 2;	// reset_mode_enable, level
	localparam int CCH_CTRL_RST_DIS    = 3;	// reset_mode_disable_ctrl, write 1
	localparam int CCH_CTRL_OUT_EN     = 4;	// output_release_enable, level
	localparam int CCH_CTRL_CLR_STAT   = 5;	// write 1: reset status flags

	// ==========================================================
	// configuration word fields
	localparam int CCH_CFG_COND_LSB    = 0;	// 2-bit switching condition
	localparam int CCH_CFG_HWG_EN      = 2;	// hardware gate in use
	localparam int CCH_CFG_RST_FUNC    = 3;	// reset function configured
	localparam int CCH_CFG_ALM_EVT     = 4;	// alarm on end/overflow
	localparam int CCH_CFG_ALM_CMP     = 5;	// alarm on comparison
	localparam int CCH_CFG_HYST_LSB    = 8;	// 8-bit hysteresis limit
	localparam int CCH_CFG_PULSE_LSB   = 16;	// 9-bit pulse length in ms
	localparam logic [31:0] CCH_CFG_MASK = 32'h01FF_FF3F;	// writable bits

	// ==========================================================
	// status word bit positions
	localparam int CCH_ST_RST_DONE  = 0;	// reset_done_flag
	localparam int CCH_ST_RST_LVL   = 1;	// reset_input_level_flag
	localparam int CCH_ST_END       = 2;	// end value reached
	localparam int CCH_ST_OVF       = 3;	// overflow performed
	localparam int CCH_ST_CMP_MET   = 4;	// compare_met_flag
	localparam int CCH_ST_DO_SET    = 5;	// output currently set
	localparam int CCH_ST_GATE      = 6;	// internal gate open
	localparam int CCH_ST_HYST      = 7;	// hysteresis armed

	// ==========================================================
	// switching conditions
	typedef enum logic [1:0] {
		CCH_COND_NEVER = 2'h0,
		CCH_COND_GE    = 2'h1,
		CCH_COND_LE    = 2'h2,
		CCH_COND_EQ    = 2'h3
	} cch_cond_e;

	// ==========================================================
	// reset values and limits
	localparam logic [31:0] CCH_RST_WORD  = 32'h0000_0000;	// all registers clear
	localparam logic [31:0] CCH_UPPER_LIM = 32'h7FFF_FFFF;	// upper count limit
	localparam logic [31:0] CCH_LOWER_LIM = 32'h8000_0000;	// lower count limit
	localparam logic [8:0]  CCH_PULSE_MAX = 9'h1FE;	// 510 ms ceiling
	localparam logic [7:0]  CCH_HYST_MIN  = 8'h02;	// below this, hysteresis off

	// ==========================================================
	// timing
	localparam int CCH_CLK_PERIOD_PS = 5000;	// 200 MHz
	localparam int CCH_MS_PS         = 1000000000;	// one millisecond
	localparam int CCH_CYC_PER_MS    = CCH_MS_PS / CCH_CLK_PERIOD_PS;

endpackage : cch_pkg

// file: logic/cch_sync_edge.sv
/*
 * cch_sync_edge: two-stage synchroniser with rising-edge detect.
 * Assumes the input is asynchronous to pclk and held for at least two cycles.
 */
`timescale 1ns/1ps
module cch_sync_edge (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      level_o,
	output logic      rise_o
);
	logic meta_r;	// first stage, read only by sync_r
	logic sync_r;	// second stage, safe level
	logic prev_r;	// delayed copy for edge detect

	// ==========================================================
	// synchroniser chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level_o = sync_r;
	assign rise_o  = sync_r & ~prev_r;	// one-cycle pulse per 0-1 edge

endmodule : cch_sync_edge

// file: logic/cch_counter.sv
/*
 * cch_counter: 32-bit periodic down counter with primary direction, plus
 * reset, latch, comparator, pulse stretcher and hysteresis; APB register port.
 * Assumes encoder-side inputs are asynchronous pins and one 200 MHz pclk.
 */
`timescale 1ns/1ps
module cch_counter #(
	parameter int CYC_PER_MS = cch_pkg::CCH_CYC_PER_MS	// cycles per millisecond tick
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        count_in,
	input  wire logic        dir_up_in,
	input  wire logic        reset_in,
	input  wire logic        latch_in,
	input  wire logic        hw_gate_in,
	output logic             do_out,
	output logic             alarm_out
);
	import cch_pkg::*;

	// ==========================================================
	// input synchronisers
	logic cnt_rise;	// count pulse
	logic rst_lvl, rst_rise;	// reset input
	logic lat_rise;	// latch input
	logic hwg_lvl;	// hardware gate level
	logic dir_lvl;	// direction level, 1 = up

	cch_sync_edge u_cnt (.pclk(pclk), .presetn(presetn), .async_in(count_in),
		.level_o(), .rise_o(cnt_rise));
	cch_sync_edge u_rst (.pclk(pclk), .presetn(presetn), .async_in(reset_in),
		.level_o(rst_lvl), .rise_o(rst_rise));
	cch_sync_edge u_lat (.pclk(pclk), .presetn(presetn), .async_in(latch_in),
		.level_o(), .rise_o(lat_rise));
	cch_sync_edge u_hwg (.pclk(pclk), .presetn(presetn), .async_in(hw_gate_in),
		.level_o(hwg_lvl), .rise_o());
	cch_sync_edge u_dir (.pclk(pclk), .presetn(presetn), .async_in(dir_up_in),
		.level_o(dir_lvl), .rise_o());

	// ==========================================================
	// registers
	logic [31:0] cfg_r;	// configuration word
	logic [31:0] load_r;	// load value
	logic [31:0] end_r;	// end value
	logic [31:0] cmp_r;	// compare value
	logic [31:0] count_r;	// live count
	logic [31:0] latch_r;	// latched count
	logic        sw_gate_r;	// software gate
	logic        rst_mode_r;	// reset_mode_enable
	logic        out_en_r;	// output_release_enable
	logic        rst_done_r;	// reset_done_flag
	logic        end_flag_r;	// end value reached
	logic        ovf_flag_r;	// overflow performed
	logic        cmp_flag_r;	// compare_met_flag
	logic        gate_prev_r;	// gate of last cycle, for activation edge
	logic        cond_prev_r;	// raw condition of last cycle
	logic        hyst_r;	// hysteresis armed
	logic [7:0]  hyst_w_r;	// band width captured when armed
	logic        held_r;	// output level for zero pulse length
	logic [8:0]  pulse_ms_r;	// remaining pulse milliseconds
	logic [31:0] tick_cnt_r;	// millisecond prescaler
	logic        alarm_r;	// alarm pulse
	logic [31:0] prdata_r;	// read data captured in setup phase

	// ==========================================================
	// apb decode
	wire         wr_acc   = psel & penable & pwrite;	// write takes effect here
	wire         rd_setup = psel & ~penable & ~pwrite;	// read data fetched here
	wire  [7:0]  ofs      = paddr[7:0];
	wire         hit_map  = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'b00) &&
	                        (ofs <= CCH_OFS_LATCH);
	wire         ro_reg   = (ofs == CCH_OFS_STATUS) || (ofs == CCH_OFS_COUNT) ||
	                        (ofs == CCH_OFS_LATCH);
	wire         wr_ctrl  = wr_acc & hit_map & (ofs == CCH_OFS_CTRL);
	wire         wr_cfg   = wr_acc & hit_map & (ofs == CCH_OFS_CFG);
	wire         wr_load  = wr_acc & hit_map & (ofs == CCH_OFS_LOAD);
	wire         wr_end   = wr_acc & hit_map & (ofs == CCH_OFS_END);
	wire         wr_cmp   = wr_acc & hit_map & (ofs == CCH_OFS_CMP);
	// control commands, one-cycle strobes on a write of 1
	wire         cmd_gset  = wr_ctrl & pwdata[CCH_CTRL_GATE_SET];
	wire         cmd_gclr  = wr_ctrl & pwdata[CCH_CTRL_GATE_CLR];
	wire         cmd_rdis  = wr_ctrl & pwdata[CCH_CTRL_RST_DIS];
	wire         cmd_clr   = wr_ctrl & pwdata[CCH_CTRL_CLR_STAT];

	// ==========================================================
	// configuration fields
	wire  [1:0]  cond_sel  = cfg_r[CCH_CFG_COND_LSB +: 2];
	wire         hwg_en    = cfg_r[CCH_CFG_HWG_EN];
	wire         rst_func  = cfg_r[CCH_CFG_RST_FUNC];
	wire         alm_evt   = cfg_r[CCH_CFG_ALM_EVT];
	wire         alm_cmp   = cfg_r[CCH_CFG_ALM_CMP];
	wire  [7:0]  hyst_cfg  = cfg_r[CCH_CFG_HYST_LSB +: 8];
	wire  [8:0]  pulse_raw = cfg_r[CCH_CFG_PULSE_LSB +: 9];
	// values above 510 are clipped rather than refused
	wire  [8:0]  pulse_cfg = (pulse_raw > CCH_PULSE_MAX) ? CCH_PULSE_MAX : pulse_raw;

	// ==========================================================
	// gate and counting step
	wire         gate      = hwg_en ? (sw_gate_r & hwg_lvl) : sw_gate_r;
	wire         activate  = gate & ~gate_prev_r;	// counter just activated
	wire         step      = gate & cnt_rise;	// one count pulse
	wire  [31:0] end_p1    = end_r + 32'h0000_0001;
	wire         at_end    = (count_r == end_p1);
	wire         at_upper  = (count_r == CCH_UPPER_LIM);
	wire         end_evt   = step & ~dir_lvl & at_end;	// reload in primary direction
	wire         ovf_evt   = step & dir_lvl & at_upper;	// wrap against it
	wire         rst_evt   = rst_rise & rst_func & rst_mode_r;
	// next count, priority: reset input, then count step
	logic [31:0] count_nxt;
	always_comb begin
		count_nxt = count_r;
		if (rst_evt) begin
			count_nxt = load_r;
		end else if (end_evt) begin
			count_nxt = load_r;
		end else if (ovf_evt) begin
			count_nxt = CCH_LOWER_LIM;
		end else if (step && dir_lvl) begin
			count_nxt = count_r + 32'h0000_0001;
		end else if (step) begin
			count_nxt = count_r - 32'h0000_0001;
		end
	end

	// ==========================================================
	// comparator, signed since the count range is two's complement
	wire signed [31:0] cnt_s = count_r;
	wire signed [31:0] cmp_s = cmp_r;
	logic cond_now;
	always_comb begin
		case (cond_sel)
			CCH_COND_GE: cond_now = (cnt_s >= cmp_s);
			CCH_COND_LE: cond_now = (cnt_s <= cmp_s);
			CCH_COND_EQ: cond_now = (cnt_s == cmp_s);
			default:     cond_now = 1'b0;	// never switch
		endcase
	end
	// a hit is the condition becoming true while the last count step was downward
	logic last_down_r;	// last count step was downward
	wire  cmp_hit = cond_now & ~cond_prev_r & last_down_r;
	// hysteresis band: distance of the count from the compare value
	wire  [31:0] diff     = (cnt_s >= cmp_s) ? (count_r - cmp_r) : (cmp_r - count_r);
	wire         in_band  = (diff < {24'h00_0000, hyst_w_r});
	wire         hyst_on  = (hyst_cfg >= CCH_HYST_MIN);
	wire         arm      = cmp_hit & hyst_on & ~hyst_r;
	wire         disarm   = hyst_r & ~in_band;	// band left
	// frozen result while armed keeps the zero-pulse output from dropping
	wire         cond_eff = cond_now | hyst_r;
	// pulse start: not while one runs or while hysteresis is armed
	wire         pulse_run   = (pulse_ms_r != 9'h000);
	wire         pulse_start = cmp_hit & ~pulse_run & ~hyst_r & (pulse_cfg != 9'h000);
	wire         ms_tick     = (tick_cnt_r == 32'(CYC_PER_MS - 1));
	// output level before release gating
	wire         do_lvl  = (pulse_cfg == 9'h000) ? held_r : pulse_run;

	// ==========================================================
	// control and configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r      <= CCH_RST_WORD;
			load_r     <= CCH_RST_WORD;
			end_r      <= CCH_RST_WORD;
			cmp_r      <= CCH_RST_WORD;
			rst_mode_r <= 1'b0;
			out_en_r   <= 1'b0;
		end else begin
			if (wr_cfg)  cfg_r  <= pwdata & CCH_CFG_MASK;
			if (wr_load) load_r <= pwdata;
			if (wr_end)  end_r  <= pwdata;
			if (wr_cmp)  cmp_r  <= pwdata;
			if (wr_ctrl) begin
				rst_mode_r <= pwdata[CCH_CTRL_RST_EN] & ~pwdata[CCH_CTRL_RST_DIS];
				out_en_r   <= pwdata[CCH_CTRL_OUT_EN];
			end
		end
	end

	// ==========================================================
	// software gate, set and reset strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_gate_r   <= 1'b0;
			gate_prev_r <= 1'b0;
		end else begin
			if (cmd_gset) begin
				sw_gate_r <= 1'b1;
			end else if (cmd_gclr) begin
				sw_gate_r <= 1'b0;
			end
			gate_prev_r <= gate;
		end
	end

	// ==========================================================
	// count, latch and direction memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r     <= CCH_RST_WORD;
			latch_r     <= CCH_RST_WORD;
			last_down_r <= 1'b0;
			cond_prev_r <= 1'b0;
		end else begin
			count_r     <= count_nxt;
			cond_prev_r <= cond_now;
			if (step) last_down_r <= ~dir_lvl;
			if (activate) begin
				latch_r <= CCH_RST_WORD;
			end else if (lat_rise && gate) begin
				latch_r <= count_r;
			end
		end
	end

	// ==========================================================
	// sticky status flags; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			end_flag_r <= 1'b0;
			ovf_flag_r <= 1'b0;
			cmp_flag_r <= 1'b0;
			rst_done_r <= 1'b0;
		end else begin
			end_flag_r <= end_evt | (end_flag_r & ~cmd_clr);
			ovf_flag_r <= ovf_evt | (ovf_flag_r & ~cmd_clr);
			cmp_flag_r <= cmp_hit | (cmp_flag_r & ~cmd_clr);
			rst_done_r <= rst_evt | (rst_done_r & ~cmd_rdis);
		end
	end

	// ==========================================================
	// hysteresis state; width captured only when arming
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hyst_r   <= 1'b0;
			hyst_w_r <= 8'h00;
		end else begin
			if (arm) begin
				hyst_r   <= 1'b1;
				hyst_w_r <= hyst_cfg;
			end else if (disarm) begin
				hyst_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// output hold and pulse timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_r     <= 1'b0;
			pulse_ms_r <= 9'h000;
			tick_cnt_r <= 32'h0000_0000;
		end else begin
			// zero pulse: set on hit, drop only when the frozen result is false
			if (cmp_hit) begin
				held_r <= 1'b1;
			end else if (!cond_eff) begin
				held_r <= 1'b0;
			end
			// free-running ms tick keeps the error under one tick
			tick_cnt_r <= ms_tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
			if (pulse_start) begin
				pulse_ms_r <= pulse_cfg;
			end else if (pulse_run && ms_tick) begin
				pulse_ms_r <= pulse_ms_r - 9'h001;
			end
		end
	end

	// ==========================================================
	// alarm pulse from events as configured
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_r <= 1'b0;
		end else begin
			alarm_r <= (alm_evt & (end_evt | ovf_evt)) |
			           (alm_cmp & cmp_hit & ~hyst_r);
		end
	end

	// ==========================================================
	// status word and read mux
	logic [31:0] status_w;
	always_comb begin
		status_w                  = 32'h0000_0000;
		status_w[CCH_ST_RST_DONE] = rst_done_r;
		status_w[CCH_ST_RST_LVL]  = rst_lvl;
		status_w[CCH_ST_END]      = end_flag_r;
		status_w[CCH_ST_OVF]      = ovf_flag_r;
		status_w[CCH_ST_CMP_MET]  = cmp_flag_r;
		status_w[CCH_ST_DO_SET]   = do_out;
		status_w[CCH_ST_GATE]     = gate;
		status_w[CCH_ST_HYST]     = hyst_r;
	end

	logic [31:0] ctrl_rd;
	always_comb begin
		ctrl_rd                 = 32'h0000_0000;
		ctrl_rd[CCH_CTRL_GATE_SET] = sw_gate_r;
		ctrl_rd[CCH_CTRL_RST_EN]   = rst_mode_r;
		ctrl_rd[CCH_CTRL_OUT_EN]   = out_en_r;
	end

	logic [31:0] rd_mux;
	always_comb begin
		case (ofs)
			CCH_OFS_CTRL:   rd_mux = ctrl_rd;
			CCH_OFS_CFG:    rd_mux = cfg_r;
			CCH_OFS_LOAD:   rd_mux = load_r;
			CCH_OFS_END:    rd_mux = end_r;
			CCH_OFS_CMP:    rd_mux = cmp_r;
			CCH_OFS_STATUS: rd_mux = status_w;
			CCH_OFS_COUNT:  rd_mux = count_r;
			CCH_OFS_LATCH:  rd_mux = latch_r;
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	// read data caught in the setup cycle, stable through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_r <= hit_map ? rd_mux : 32'h0000_0000;
		end
	end

	// ==========================================================
	// outputs
	assign prdata    = prdata_r;
	assign pready    = 1'b1;	// never waits
	// unmapped address or write to a read-only word
	assign pslverr   = psel & penable & (~hit_map | (pwrite & ro_reg));
	assign do_out    = out_en_r & do_lvl;
	assign alarm_out = alarm_r;

endmodule : cch_counter

// file: testbench/cch_counter_properties.sv
/*
 * cch_counter_properties: port-level checks on cch_counter, bound below.
 * Assumes one pclk domain and shadows of CFG and CTRL taken from APB writes.
 */
`timescale 1ns/1ps
module cch_counter_properties #(
	parameter int CYC_PER_MS = 20	// cycles per millisecond tick
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        do_out,
	input wire logic        alarm_out
);
	import cch_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// shadow state
	logic [31:0] cfg_r;	// configuration as last written
	logic        oen_r;	// output release as last written
	logic [31:0] run_r;	// cycles the output has stood high
	wire         acc_w = psel && penable;	// access phase
	wire         wok_w = acc_w && pwrite && !pslverr;	// accepted write
	// equality with a pulse and no hysteresis, where pulse length rules alone
	wire         eqp_w = cfg_r[1:0] == CCH_COND_EQ && cfg_r[24:16] != 9'h0
		&& cfg_r[15:8] < CCH_HYST_MIN;
	wire  [31:0] lim_w = (32'(cfg_r[24:16]) + 32'h2) * 32'(CYC_PER_MS);
	// shadows follow only writes the slave accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= 32'h0;
			oen_r <= 1'b0;
			run_r <= 32'h0;
		end else begin
			if (wok_w && paddr == 32'(CCH_OFS_CFG)) cfg_r <= pwdata & CCH_CFG_MASK;
			if (wok_w && paddr == 32'(CCH_OFS_CTRL)) oen_r <= pwdata[CCH_CTRL_OUT_EN];
			run_r <= do_out ? run_r + 32'h1 : 32'h0;
		end
	end
	// ==========================================================
	// named steps of an APB access
	sequence s_bad_addr;
		acc_w && (paddr > 32'h1C || paddr[1:0] != 2'h0);
	endsequence
	sequence s_ro_write;
		acc_w && pwrite && paddr inside {32'h14, 32'h18, 32'h1C};
	endsequence
	// ==========================================================
	// assertions
	chk_do_released: assert property (do_out |-> oen_r)
		else $error("output set while not released");
	chk_alarm_cause: assert property (alarm_out |-> cfg_r[5:4] != 2'h0)
		else $error("alarm without alarm enable");
	chk_alarm_pulse: assert property ($rose(alarm_out) |=> !alarm_out)
		else $error("alarm longer than one cycle");
	chk_bad_addr: assert property (s_bad_addr |-> pslverr && pready)
		else $error("bad address not refused");
	chk_ro_write: assert property (s_ro_write |-> pslverr)
		else $error("read-only write not refused");
	chk_good_ok: assert property (acc_w && paddr <= 32'h10 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("legal access refused");
	chk_pulse_cap: assert property (eqp_w && do_out |-> run_r < lim_w)
		else $error("pulse ran too long");
	chk_pulse_full: assert property (eqp_w && oen_r && $past(oen_r)
		&& $fell(do_out) |-> run_r + 32'(2 * CYC_PER_MS) >= 32'(cfg_r[24:16]) * 32'(CYC_PER_MS))
		else $error("pulse ended too early");
endmodule : cch_counter_properties

bind cch_counter cch_counter_properties #(.CYC_PER_MS(CYC_PER_MS)) u_cch_counter_properties (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.do_out(do_out), .alarm_out(alarm_out)
);

// file: testbench/cch_apb_host.sv
/*
 * cch_apb_host: APB master standing in for the fieldbus host.
 * Assumes the bench calls xfer one at a time; only the bench timeout ends a wait.
 */
`timescale 1ns/1ps
module cch_apb_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [31:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic err_q;	// response of the last transfer
	initial begin
		{psel, penable, pwrite, err_q} = 4'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
	end
	// setup, then access held until pready; compare value and release go through here
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : cch_apb_host

// file: testbench/counter_compare_latch_hysteresis_test.sv
/*
 * counter_compare_latch_hysteresis_test: self-checking bench for cch_counter.
 * Assumes the bound checker and cch_apb_host; pins are driven here.
 */
`timescale 1ns/1ps
module counter_compare_latch_hysteresis_test;
	import cch_pkg::*;
	// ==========================================================
	// signals
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, do_out, alarm_out;
	logic        count_in, dir_up_in, reset_in, latch_in, hw_gate_in;
	logic [31:0] paddr, pwdata, prdata, q, seed, ld, en, cmp, cnt, cfg;
	int          error_cnt = 0, checks_done = 0, cyc = 0, alarm_n = 0;
	localparam logic [31:0] KEEP = 32'h14;	// reset mode and output release kept on
	cch_counter #(.CYC_PER_MS(20)) u_cch_counter (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .count_in(count_in),
		.dir_up_in(dir_up_in), .reset_in(reset_in), .latch_in(latch_in),
		.hw_gate_in(hw_gate_in), .do_out(do_out), .alarm_out(alarm_out));
	cch_apb_host u_cch_apb_host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;
	// ==========================================================
	// helpers
	function automatic logic [31:0] bm(input int b);
		return 32'h1 << b;
	endfunction : bm
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// down step: at end+1 the next pulse reloads
	function automatic logic [31:0] step_dn(input logic [31:0] c, l, e);
		return (c == e + 32'h1) ? l : c - 32'h1;
	endfunction : step_dn
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		u_cch_apb_host.xfer(1'b1, {24'h0, a}, d, r);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		u_cch_apb_host.xfer(1'b0, {24'h0, a}, 32'h0, r);
		chk(r, exp);
	endtask : rc
	// pin pulse, long enough both ways for the synchroniser
	task automatic pin(input int k);
		@(posedge pclk);
		count_in <= (k == 0);
		reset_in <= (k == 1);
		latch_in <= (k == 2);
		repeat (3) @(posedge pclk);
		{count_in, reset_in, latch_in} <= 3'h0;
		repeat (6) @(posedge pclk);
	endtask : pin
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	// hang guard, far above the few hundred cycles needed
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (alarm_out) alarm_n <= alarm_n + 1;	// one-cycle alarm pulses
		if (cyc == 8000) begin
			error_cnt++;
			close_out();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		presetn = 1'b0;
		{count_in, dir_up_in, reset_in, latch_in, hw_gate_in} = 5'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 32; a += 4) rc(8'(a), 32'h0);
		u_cch_apb_host.xfer(1'b0, 32'h20, 32'h0, q);
		chk({31'h0, u_cch_apb_host.err_q}, 32'h1);
		u_cch_apb_host.xfer(1'b1, 32'h14, 32'hFF, q);
		chk({31'h0, u_cch_apb_host.err_q}, 32'h1);
		// random load, end below it, compare two steps down
		seed = lfsr(32'h42);
		ld = {23'h0, 1'b1, seed[7:0]};
		seed = lfsr(seed);
		en = ld - 32'h4 - {30'h0, seed[1:0]};
		cmp = ld - 32'h2;
		cfg = 32'(CCH_COND_EQ) | bm(CCH_CFG_RST_FUNC) | 32'h0003_0030;
		wr(CCH_OFS_LOAD, ld);
		wr(CCH_OFS_END, en);
		wr(CCH_OFS_CMP, cmp);
		wr(CCH_OFS_CFG, cfg);
		wr(CCH_OFS_CTRL, KEEP | bm(CCH_CTRL_GATE_SET));
		reset_in <= 1'b1;
		repeat (4) @(posedge pclk);
		rc(CCH_OFS_STATUS, 32'h43);
		reset_in <= 1'b0;
		repeat (4) @(posedge pclk);
		rc(CCH_OFS_COUNT, ld);
		wr(CCH_OFS_CTRL, bm(CCH_CTRL_RST_DIS) | bm(CCH_CTRL_OUT_EN));
		rc(CCH_OFS_STATUS, bm(CCH_ST_GATE));
		cnt = ld;
		for (int i = 0; i < int'(ld - en); i++) begin
			pin(0);
			cnt = step_dn(cnt, ld, en);
			if (cnt == cmp) chk({31'h0, do_out}, 32'h1);
			rc(CCH_OFS_COUNT, cnt);
		end
		repeat (80) @(posedge pclk);
		chk({31'h0, do_out}, 32'h0);
		rc(CCH_OFS_STATUS, 32'h54);
		wr(CCH_OFS_CTRL, KEEP | bm(CCH_CTRL_CLR_STAT));
		rc(CCH_OFS_STATUS, bm(CCH_ST_GATE));
		pin(2);
		rc(CCH_OFS_LATCH, ld);
		wr(CCH_OFS_CTRL, KEEP | bm(CCH_CTRL_GATE_CLR));
		pin(0);
		rc(CCH_OFS_COUNT, ld);
		wr(CCH_OFS_CTRL, KEEP | bm(CCH_CTRL_GATE_SET));
		rc(CCH_OFS_LATCH, 32'h0);
		wr(CCH_OFS_CFG, cfg | bm(CCH_CFG_HWG_EN));
		pin(0);
		rc(CCH_OFS_COUNT, ld);
		hw_gate_in <= 1'b1;
		pin(0);
		rc(CCH_OFS_COUNT, ld - 32'h1);
		// wrap at the upper limit
		wr(CCH_OFS_LOAD, CCH_UPPER_LIM);
		wr(CCH_OFS_CTRL, KEEP);
		pin(1);
		dir_up_in <= 1'b1;
		pin(0);
		rc(CCH_OFS_COUNT, CCH_LOWER_LIM);
		rc(CCH_OFS_STATUS, 32'h49);
		// level output, band of 3 around the compare value, no alarms
		wr(CCH_OFS_LOAD, ld);
		wr(CCH_OFS_CFG, 32'(CCH_COND_LE) | bm(CCH_CFG_RST_FUNC) | 32'h0300);
		pin(1);
		dir_up_in <= 1'b0;
		pin(0);
		pin(0);
		chk({31'h0, do_out}, 32'h1);
		dir_up_in <= 1'b1;
		pin(0);
		pin(0);
		chk({31'h0, do_out}, 32'h1);
		pin(0);
		chk({31'h0, do_out}, 32'h0);
		chk(32'(alarm_n), 32'h3);
		close_out();
	end
endmodule : counter_compare_latch_hysteresis_test
